// ### hdl/cim_pkg.sv
// shared constants and types of the channel synchronizer controller
package cim_pkg;
  localparam int CIM_NCH = 8;
  localparam int CIM_DW = 24;
  localparam int CIM_AW = 8;
  localparam int CIM_CHAN_W = 3;
  localparam int CIM_CNT_W = 16;

  localparam logic [CIM_AW-1:0] CIM_CTRL_OFF = 8'h00;
  localparam logic [CIM_AW-1:0] CIM_STAT_OFF = 8'h04;
  localparam logic [CIM_AW-1:0] CIM_CMD_OFF = 8'h08;
  localparam logic [CIM_AW-1:0] CIM_RX_OFF = 8'h0c;
  localparam logic [CIM_AW-1:0] CIM_TX_OFF = 8'h10;
  localparam logic [CIM_AW-1:0] CIM_CNT_OFF = 8'h14;

  localparam int CIM_CTRL_START_BIT = 0;
  localparam int CIM_CTRL_ABORT_BIT = 1;
  localparam int CIM_CTRL_CHAN_LSB = 4;

  localparam int CIM_STAT_BUSY_BIT = 0;
  localparam int CIM_STAT_RXF_BIT = 1;
  localparam int CIM_STAT_TXF_BIT = 2;
  localparam int CIM_STAT_IRQ_BIT = 3;
  localparam int CIM_STAT_PERR_BIT = 4;
  localparam int CIM_STAT_CHAN_LSB = 8;
  localparam int CIM_STAT_STATE_LSB = 12;

  localparam int CIM_CMD_OUT_BIT = 0;
  localparam int CIM_CMD_CHAIN_BIT = 1;
  localparam int CIM_CMD_EOI_BIT = 2;
  localparam int CIM_CMD_NOP_BIT = 3;

  localparam logic [31:0] CIM_RDATA_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_NEXT,
    ST_OUT,
    ST_IN
  } cim_state_t;
endpackage

// ### hdl/cim_grant_watch.sv
// trailing-edge detector for the selected grant, with flag capture
`timescale 1ns/1ps
module cim_grant_watch (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic grant,
  input wire logic last_word,
  input wire logic par_err,
  output logic fall,
  output logic last_word_s,
  output logic par_err_s
);
  typedef struct packed {
    logic grant;
    logic last_word;
    logic par_err;
  } cim_gw_t;

  cim_gw_t q;
  cim_gw_t d;

  always_comb begin
    d.grant = grant;
    d.last_word = last_word;
    d.par_err = par_err;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // flags as they stood in the last cycle the grant was high
  assign fall = q.grant & ~grant;
  assign last_word_s = q.last_word;
  assign par_err_s = q.par_err;
endmodule

// ### hdl/cim_sync_ctrl.sv
// channel synchronizer controller: apb registers and channel bus exchange
//
// How it works
// - last-word flag sampled at grant trailing edge
// - parity error sampled at grant trailing edge
// - one request and grant line per channel
// - drop outbound request on grant, re-raise when ready
// - grant gives bus ownership, allows request drop
// - start command raises an order fetch request
// - chaining order triggers fresh fetch on completion
// - hold channel address and command whole transfer
// - last word: interrupt if end flag, chain
// - any error cancels chaining, forces interrupt
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module cim_sync_ctrl #(
  parameter int NCH = cim_pkg::CIM_NCH,
  parameter int DW = cim_pkg::CIM_DW
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cim_pkg::CIM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NCH-1:0] order_fetch_request,
  output logic [NCH-1:0] outbound_word_request,
  output logic [NCH-1:0] inbound_word_request,
  input wire logic [NCH-1:0] bus_grant,
  input wire logic output_valid_strobe,
  input wire logic last_word_flag,
  input wire logic parity_error,
  input wire logic [DW-1:0] cdb_in,
  output logic [DW-1:0] cdb_out,
  output logic cdb_oe,
  output logic device_irq
);
  import cim_pkg::*;

  if (NCH < 1 || NCH > 8) begin : g_nch_check
    $error("NCH must lie between 1 and 8");
  end
  if (DW < 4 || DW > 32) begin : g_dw_check
    $error("DW must lie between 4 and 32");
  end
  if (NCH > (1 << CIM_CHAN_W)) begin : g_chan_check
    $error("NCH exceeds the channel field");
  end
  if (CIM_CNT_W > 32) begin : g_cnt_check
    $error("word count wider than a register");
  end

  typedef struct packed {
    cim_state_t st;
    logic [CIM_CHAN_W-1:0] chan;
    logic [NCH-1:0] ofr;
    logic [NCH-1:0] owr;
    logic [NCH-1:0] iwr;
    logic [DW-1:0] cdb_out;
    logic cdb_oe;
    logic [DW-1:0] cmd;
    logic [DW-1:0] rx;
    logic [DW-1:0] tx;
    logic rx_full;
    logic tx_full;
    logic granted;
    logic irq;
    logic perr;
    logic order_err;
    logic [CIM_CNT_W-1:0] words;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cim_reg_t;

  cim_reg_t q;
  cim_reg_t d;

  logic [NCH-1:0] sel;
  logic [NCH-1:0] hit;
  logic grant;
  logic fall;
  logic lw_s;
  logic pe_s;

  // per-channel select and grant pickup
  for (genvar i = 0; i < NCH; i++) begin : g_chan
    assign sel[i] = (q.chan == CIM_CHAN_W'(i));
    assign hit[i] = bus_grant[i] & sel[i];
  end
  assign grant = |hit;

  cim_grant_watch u_watch (
    .clock(clock),
    .arst_n(arst_n),
    .grant(grant),
    .last_word(last_word_flag),
    .par_err(parity_error),
    .fall(fall),
    .last_word_s(lw_s),
    .par_err_s(pe_s)
  );

  logic prep;
  logic commit;
  logic wr;
  logic rd;
  logic mapped;
  logic [CIM_CHAN_W-1:0] wchan;
  logic start_ok;
  logic order_end;
  logic end_err;
  logic [31:0] stat;
  logic [NCH-1:0] new_sel;
  logic done;
  logic abort_wr;
  logic stat_wr;
  logic tx_wr;
  logic rx_rd;

  always_comb begin
    d = q;
    order_end = 1'b0;
    end_err = 1'b0;
    prep = psel & penable & ~q.pready;
    commit = psel & penable & q.pready;
    wr = commit & pwrite;
    rd = commit & ~pwrite;
    stat_wr = wr && paddr == CIM_STAT_OFF;
    tx_wr = wr && paddr == CIM_TX_OFF;
    rx_rd = rd && paddr == CIM_RX_OFF;
    abort_wr = wr && paddr == CIM_CTRL_OFF && pwdata[CIM_CTRL_ABORT_BIT];
    // a fall left over from an aborted grant is no completion
    done = fall & q.granted;
    wchan = pwdata[CIM_CTRL_CHAN_LSB +: CIM_CHAN_W];
    new_sel = NCH'(1) << wchan;
    case (paddr)
      CIM_CTRL_OFF, CIM_STAT_OFF, CIM_CMD_OFF,
      CIM_RX_OFF, CIM_TX_OFF, CIM_CNT_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase

    stat = '0;
    stat[CIM_STAT_BUSY_BIT] = (q.st != ST_IDLE);
    stat[CIM_STAT_RXF_BIT] = q.rx_full;
    stat[CIM_STAT_TXF_BIT] = q.tx_full;
    stat[CIM_STAT_IRQ_BIT] = q.irq;
    stat[CIM_STAT_PERR_BIT] = q.perr;
    stat[CIM_STAT_CHAN_LSB +: CIM_CHAN_W] = q.chan;
    stat[CIM_STAT_STATE_LSB +: 3] = q.st;

    // apb: access phase is two cycles, ready from a flop
    d.pready = prep;
    d.pslverr = prep & ~mapped;
    if (prep) begin
      case (paddr)
        CIM_CTRL_OFF: d.prdata = 32'(q.chan) << CIM_CTRL_CHAN_LSB;
        CIM_STAT_OFF: d.prdata = stat;
        CIM_CMD_OFF: d.prdata = 32'(q.cmd);
        CIM_RX_OFF: d.prdata = 32'(q.rx);
        CIM_TX_OFF: d.prdata = 32'(q.tx);
        CIM_CNT_OFF: d.prdata = 32'(q.words);
        default: d.prdata = CIM_RDATA_RST;
      endcase
    end

    // software clears first so hardware sets below win
    if (rx_rd) begin
      d.rx_full = 1'b0;
    end
    if (stat_wr) begin
      if (pwdata[CIM_STAT_IRQ_BIT]) begin
        d.irq = 1'b0;
      end
      if (pwdata[CIM_STAT_PERR_BIT]) begin
        d.perr = 1'b0;
      end
    end
    if (tx_wr && !q.tx_full) begin
      d.tx = pwdata[DW-1:0];
      d.tx_full = 1'b1;
    end
    start_ok = wr && paddr == CIM_CTRL_OFF && pwdata[CIM_CTRL_START_BIT] &&
               q.st == ST_IDLE && (32'(wchan) < NCH);

    case (q.st)
      ST_IDLE: begin
        if (start_ok) begin
          d.chan = wchan;
          d.ofr = new_sel;
          d.words = '0;
          d.order_err = 1'b0;
          d.granted = 1'b0;
          d.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (grant && !q.granted) begin
          d.granted = 1'b1;
          d.ofr = '0;
        end
        if (grant && output_valid_strobe) begin
          d.cmd = cdb_in;
        end
        if (done) begin
          d.granted = 1'b0;
          if (pe_s) begin
            end_err = 1'b1;
            order_end = 1'b1;
          end else if (lw_s || q.cmd[CIM_CMD_NOP_BIT]) begin
            order_end = 1'b1;
          end else begin
            d.st = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        // outbound waits until software has taken rx
        if (q.cmd[CIM_CMD_OUT_BIT]) begin
          if (!q.rx_full) begin
            d.owr = sel;
            d.st = ST_OUT;
          end
        end else if (q.tx_full) begin
          d.iwr = sel;
          d.cdb_out = q.tx;
          d.st = ST_IN;
        end
      end
      ST_OUT: begin
        if (grant && !q.granted) begin
          d.granted = 1'b1;
          d.owr = '0;
        end
        if (grant && output_valid_strobe) begin
          d.rx = cdb_in;
          d.rx_full = 1'b1;
        end
        if (done) begin
          d.granted = 1'b0;
          d.words = q.words + CIM_CNT_W'(1);
          end_err = pe_s;
          if (lw_s || pe_s) begin
            order_end = 1'b1;
          end else begin
            d.st = ST_NEXT;
          end
        end
      end
      ST_IN: begin
        if (grant && !q.granted) begin
          d.granted = 1'b1;
          d.iwr = '0;
          d.cdb_oe = 1'b1;
        end
        if (done) begin
          d.granted = 1'b0;
          d.cdb_oe = 1'b0;
          d.tx_full = 1'b0;
          d.words = q.words + CIM_CNT_W'(1);
          end_err = pe_s;
          if (lw_s || pe_s) begin
            order_end = 1'b1;
          end else begin
            d.st = ST_NEXT;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    if (end_err) begin
      d.perr = 1'b1;
      d.order_err = 1'b1;
    end

    // end of order: interrupt, chaining or error override
    if (order_end) begin
      d.st = ST_IDLE;
      if (end_err || q.order_err) begin
        d.irq = 1'b1;
      end else begin
        if (q.cmd[CIM_CMD_EOI_BIT]) begin
          d.irq = 1'b1;
        end
        if (q.cmd[CIM_CMD_CHAIN_BIT]) begin
          d.ofr = sel;
          d.words = '0;
          d.st = ST_FETCH;
        end
      end
    end

    // abort drops every request line and the bus drive at once; device_irq keeps its value
    if (abort_wr) begin
      d.st = ST_IDLE;
      d.ofr = '0;
      d.owr = '0;
      d.iwr = '0;
      d.cdb_oe = 1'b0;
      d.granted = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign order_fetch_request = q.ofr;
  assign outbound_word_request = q.owr;
  assign inbound_word_request = q.iwr;
  assign cdb_out = q.cdb_out;
  assign cdb_oe = q.cdb_oe;
  assign device_irq = q.irq;
endmodule

// ### tb/cim_sync_ctrl_checker.sv
// port assertions for the channel synchronizer controller
`timescale 1ns/1ps
module cim_sync_ctrl_checker #(
  parameter int NCH = 8,
  parameter int DW = 24
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NCH-1:0] order_fetch_request,
  input wire logic [NCH-1:0] outbound_word_request,
  input wire logic [NCH-1:0] inbound_word_request,
  input wire logic [NCH-1:0] bus_grant,
  input wire logic [DW-1:0] cdb_out,
  input wire logic cdb_oe,
  input wire logic device_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_answer; psel && penable && !pready |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("pready late");
  property p_slverr; pslverr |-> pready; endproperty
  a_slverr: assert property (p_slverr) else $error("stray pslverr");
  property p_onehot;
    $onehot0(order_fetch_request) && $onehot0(outbound_word_request)
      && $onehot0(inbound_word_request);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("request not one-hot");
  property p_kind;
    $onehot0({|order_fetch_request, |outbound_word_request,
      |inbound_word_request});
  endproperty
  a_kind: assert property (p_kind)
    else $error("two request kinds");
  property p_drop;
    |(bus_grant & (order_fetch_request | outbound_word_request
      | inbound_word_request)) |=> ((order_fetch_request
      | outbound_word_request | inbound_word_request)
      & $past(bus_grant)) == '0;
  endproperty
  a_drop: assert property (p_drop)
    else $error("request kept after grant");
  property p_own; cdb_oe |-> $past(|bus_grant); endproperty
  a_own: assert property (p_own)
    else $error("bus driven without grant");
  property p_hold; cdb_oe && $past(cdb_oe) |-> $stable(cdb_out); endproperty
  a_hold: assert property (p_hold)
    else $error("bus data moved");
  property p_irq;
    device_irq && !(psel && penable && pready && pwrite) |=> device_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq lost");
  property p_raise; $rose(|outbound_word_request) |-> !$past(|bus_grant);
  endproperty
  a_raise: assert property (p_raise)
    else $error("request raised in grant");
endmodule
bind cim_sync_ctrl cim_sync_ctrl_checker #(.NCH(NCH), .DW(DW)) chk_inst (
  .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .order_fetch_request(order_fetch_request),
  .outbound_word_request(outbound_word_request),
  .inbound_word_request(inbound_word_request), .bus_grant(bus_grant),
  .cdb_out(cdb_out), .cdb_oe(cdb_oe), .device_irq(device_irq));

// ### tb/cim_master_model.sv
// behavioural channel master facing the synchronizer
`timescale 1ns/1ps
module cim_master_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] order_fetch_request,
  input wire logic [7:0] outbound_word_request,
  input wire logic [7:0] inbound_word_request,
  input wire logic [23:0] cdb_out,
  input wire logic cdb_oe,
  input wire logic [23:0] cmd,
  input wire logic [23:0] cmd2,
  input wire logic [7:0] words,
  input wire logic [3:0] slow,
  input wire logic perr_on,
  output logic [7:0] bus_grant,
  output logic output_valid_strobe,
  output logic last_word_flag,
  output logic parity_error,
  output logic [23:0] m_cdb,
  output logic [23:0] rx_word,
  output logic [7:0] nfetch
);
  logic [7:0] req, pick, sent;
  logic [1:0] hold;
  logic [3:0] dly;
  assign req = order_fetch_request | outbound_word_request
    | inbound_word_request;
  assign pick = req & (~req + 8'h01);
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bus_grant <= 8'h00; output_valid_strobe <= 1'b0;
      last_word_flag <= 1'b0; parity_error <= 1'b0; m_cdb <= 24'h000000;
      rx_word <= 24'h000000; nfetch <= 8'h00; sent <= 8'h00;
      hold <= 2'd0; dly <= 4'h0;
    end else if (bus_grant != 8'h00) begin
      if (cdb_oe) rx_word <= cdb_out;
      hold <= hold - 2'd1;
      if (hold == 2'd0) begin
        bus_grant <= 8'h00; output_valid_strobe <= 1'b0;
        last_word_flag <= 1'b0; parity_error <= 1'b0;
        m_cdb <= ~m_cdb;
      end
    end else if (req == 8'h00 || dly != slow) begin
      // memory wait before service
      dly <= (req == 8'h00) ? 4'h0 : dly + 4'h1;
      m_cdb <= ~m_cdb;
    end else begin
      dly <= 4'h0; hold <= 2'd2;
      bus_grant <= pick;
      parity_error <= perr_on;
      output_valid_strobe <= !(|inbound_word_request);
      if (|order_fetch_request) begin
        m_cdb <= (nfetch == 8'h00) ? cmd : cmd2;
        nfetch <= nfetch + 8'h01;
        sent <= 8'h00;
      end else begin
        m_cdb <= (|outbound_word_request) ? 24'ha50000 + sent : ~m_cdb;
        sent <= sent + 8'h01;
        last_word_flag <= (sent + 8'h01 == words);
      end
    end
  end
endmodule

// ### tb/cim_sync_ctrl_tb.sv
// self-checking bench for the channel synchronizer controller
`timescale 1ns/1ps
module cim_sync_ctrl_tb;
  import cim_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] v; logic e;} cim_row_t;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, cdb_oe;
  logic strobe, lwf, perr, device_irq, perr_on, err;
  logic [7:0] paddr, words, nfetch, grant, ofr, owr, iwr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] cdb_in, cdb_out, m_cdb, rx_word, cmd, cmd2;
  logic [3:0] slow;
  int fails, tests_run, cyc, n;
  cim_row_t rows[6] = '{'{CIM_CTRL_OFF, 0, 0}, '{CIM_STAT_OFF, 0, 0},
    '{CIM_CMD_OFF, 0, 0}, '{CIM_RX_OFF, 0, 0}, '{CIM_CNT_OFF, 0, 0},
    '{8'h18, 0, 1}};
  assign cdb_in = cdb_oe ? cdb_out : m_cdb;
  cim_sync_ctrl cim_sync_ctrl_inst (.clock(clock), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .order_fetch_request(ofr), .outbound_word_request(owr),
    .inbound_word_request(iwr), .bus_grant(grant),
    .output_valid_strobe(strobe), .last_word_flag(lwf),
    .parity_error(perr), .cdb_in(cdb_in), .cdb_out(cdb_out),
    .cdb_oe(cdb_oe), .device_irq(device_irq));
  cim_master_model cim_master_model_inst (.clock(clock), .arst_n(arst_n),
    .order_fetch_request(ofr), .outbound_word_request(owr),
    .inbound_word_request(iwr), .cdb_out(cdb_out), .cdb_oe(cdb_oe),
    .cmd(cmd), .cmd2(cmd2), .words(words), .slow(slow), .perr_on(perr_on),
    .bus_grant(grant), .output_valid_strobe(strobe), .last_word_flag(lwf),
    .parity_error(perr), .m_cdb(m_cdb), .rx_word(rx_word), .nfetch(nfetch));
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 40);
    if (k >= 40) begin fails++; close_out; end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_stat(int b);
    n = 0;
    do begin apb(0, CIM_STAT_OFF, 0); n++; end while (rd[b] !== 1'b1 && n < 60);
  endtask
  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
  endtask
  initial begin clock = 0; forever #25 clock = ~clock; end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin fails++; close_out; end
  end
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; perr_on = 0;
    cmd = 24'hc30005; cmd2 = 24'h000008; words = 2; slow = 3;
    do_reset;
    foreach (rows[i]) begin
      apb(0, rows[i].a, 0);
      check("reg", rd, rows[i].v);
      check("slverr", {31'h0, err}, {31'h0, rows[i].e});
    end
    apb(1, CIM_CTRL_OFF, 32'h31);
    wait_stat(CIM_STAT_RXF_BIT);
    repeat (10) @(posedge clock);
    check("owr held", {24'h0, owr}, 0);
    apb(0, CIM_CMD_OFF, 0); check("cmd", rd, 32'h00c30005);
    apb(0, CIM_RX_OFF, 0); check("rx0", rd, 32'h00a50000);
    wait_stat(CIM_STAT_IRQ_BIT);
    check("stat", rd, 32'h0000030a);
    apb(0, CIM_RX_OFF, 0); check("rx1", rd, 32'h00a50001);
    apb(0, CIM_CNT_OFF, 0); check("count", rd, 32'h2);
    apb(1, CIM_STAT_OFF, 32'h8);
    check("irq clr", {31'h0, device_irq}, 0);
    cmd <= 24'h000002; words <= 1; slow <= 0;
    do_reset;
    apb(1, CIM_TX_OFF, 32'h00123456);
    apb(1, CIM_CTRL_OFF, 32'h01);
    n = 0;
    while (nfetch !== 8'h02 && n < 200) begin @(posedge clock); n++; end
    repeat (10) @(posedge clock);
    check("in word", {8'h0, rx_word}, 32'h00123456);
    check("chain", {24'h0, nfetch}, 2);
    check("no irq", {31'h0, device_irq}, 0);
    apb(0, CIM_CMD_OFF, 0); check("cmd2", rd, 32'h8);
    cmd <= 24'h000003; perr_on <= 1;
    do_reset;
    apb(1, CIM_CTRL_OFF, 32'h71);
    wait_stat(CIM_STAT_IRQ_BIT);
    check("perr", {31'h0, rd[CIM_STAT_PERR_BIT]}, 1);
    repeat (20) @(posedge clock);
    check("no chain", {24'h0, nfetch}, 1);
    check("forced irq", {31'h0, device_irq}, 1);
    slow <= 4'hf;
    apb(1, CIM_CTRL_OFF, 32'h11);
    check("ofr up", {24'h0, ofr}, 32'h2);
    apb(1, CIM_CTRL_OFF, 32'h02);
    check("abort", {24'h0, ofr}, 0);
    repeat (20) @(posedge clock);
    check("no grant", {24'h0, nfetch}, 1);
    apb(0, CIM_STAT_OFF, 0);
    check("idle", {31'h0, rd[CIM_STAT_BUSY_BIT]}, 0);
    close_out;
  end
endmodule
